// >>> swk_trim_pkg.sv
// Package: register map, field layout, reset values and codes
// for the selective-wake trim and recovery register bank.
// Assumes a byte-wide register port with 7-bit addresses.
package swk_trim_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [6:0] ADDR_OSC_TRIM_LOW = 7'h38;
	localparam logic [6:0] ADDR_WAKE_OPTIONS = 7'h39;
	localparam logic [6:0] ADDR_CAL_HIGH = 7'h3a;
	localparam logic [6:0] ADDR_CAL_LOW = 7'h3b;
	localparam logic [6:0] ADDR_RECOVERY_ONE = 7'h3c;
	localparam logic [6:0] ADDR_RECOVERY_TWO = 7'h3d;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int RX_SEL_BIT = 7;
	localparam int COARSE_MSB = 4;
	localparam int FILT_LSB = 2;
	localparam int ENABLE_BIT = 0;

	// ------------------------------------------------------------
	// Reset values and codes
	// ------------------------------------------------------------
	localparam logic [7:0] RST_TRIM_LOW = 8'h00;
	localparam logic [4:0] RST_COARSE = 5'h00;
	localparam logic [7:0] RST_CAL = 8'h00;
	localparam logic [1:0] RST_FILT = 2'h1;
	localparam logic [1:0] RST_CLK_SEL = 2'h0;
	localparam logic RST_RX_SEL = 1'b0;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic [7:0] RST_RDATA = 8'h00;
	localparam logic [1:0] TRIM_UNLOCK = 2'h3;
	localparam logic [7:0] MASK_OPTIONS = 8'h9f;
	localparam logic [7:0] MASK_RECOVERY_ONE = 8'h0d;
	localparam logic [7:0] MASK_RECOVERY_TWO = 8'h03;

	// Filter time constants and edge-spacing bounds
	localparam logic [5:0] TC_8 = 6'h08;
	localparam logic [5:0] TC_16 = 6'h10;
	localparam logic [5:0] TC_32 = 6'h20;
	localparam logic [3:0] SPACE_SHORT_MAX = 4'h3;
	localparam logic [3:0] SPACE_MID_MAX = 4'h8;

	typedef enum logic [1:0] {
		FILT_8 = 2'h0,
		FILT_16 = 2'h1,
		FILT_32 = 2'h2,
		FILT_ADAPT = 2'h3
	} filt_sel_t;

	// Recovery clock in MHz per select code
	typedef enum logic [1:0] {
		CLK_80 = 2'h0,
		CLK_40 = 2'h1,
		CLK_20 = 2'h2,
		CLK_10 = 2'h3
	} clk_sel_t;

	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] wdata;
		logic wr;
	} reg_req_t;

	typedef struct packed {
		logic [12:0] oscillator_trim;
		logic wake_receiver_select;
		filt_sel_t filter_constant_select;
		logic recovery_enable;
		clk_sel_t recovery_clock_select;
	} cfg_t;

endpackage

// >>> swk_trim_regs.sv
// Register bank for oscillator trim, wake receiver choice,
// calibration status and recovery filter and clock settings.
// Assumes the serial front end delivers decoded byte accesses
// and that measurement inputs are already on clk.
//
// How it works
// - Low trim byte writable only when unlocked
// - Trim bits 4:0 are fine step
// - Trim bits 7:5 set temperature coefficient
// - Coarse trim in options 4:0, unlocked
// - Options bit 7 picks wake receiver
// - Reserved bits read back zero
// - Calibration bytes read-only, reset zero
// - Filter codes 0..2 give 8,16,32
// - Code 3 adapts constant to edge spacing
// - Control-one bit 0 enables recovery
// - Control-two bits 1:0 pick recovery clock
`timescale 1ns/1ps

module swk_trim_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register access
	input wire swk_trim_pkg::reg_req_t req,
	input wire logic [1:0] trim_enable,
	output logic [7:0] rdata,
	// Recovery measurement
	input wire logic cal_valid,
	input wire logic [15:0] cal_value,
	input wire logic [3:0] edge_spacing,
	// Configuration out
	output swk_trim_pkg::cfg_t cfg,
	output logic [5:0] filter_time_constant
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] trim_low;
	logic [4:0] coarse;
	logic rx_sel;
	logic [7:0] cal_high;
	logic [7:0] cal_low;
	swk_trim_pkg::filt_sel_t filt;
	logic rec_en;
	swk_trim_pkg::clk_sel_t clk_sel;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire unlocked = trim_enable == swk_trim_pkg::TRIM_UNLOCK;
	wire wr_trim = req.wr && req.addr == swk_trim_pkg::ADDR_OSC_TRIM_LOW;
	wire wr_opt = req.wr && req.addr == swk_trim_pkg::ADDR_WAKE_OPTIONS;
	wire wr_one = req.wr && req.addr == swk_trim_pkg::ADDR_RECOVERY_ONE;
	wire wr_two = req.wr && req.addr == swk_trim_pkg::ADDR_RECOVERY_TWO;
	wire [7:0] opt_val = {rx_sel, 2'h0, coarse};
	wire [7:0] one_val = {4'h0, filt, 1'b0, rec_en};
	wire [7:0] two_val = {6'h0, clk_sel};
	logic [7:0] next_rdata;

	always_comb begin
		case (req.addr)
			swk_trim_pkg::ADDR_OSC_TRIM_LOW: next_rdata = trim_low;
			swk_trim_pkg::ADDR_WAKE_OPTIONS: next_rdata = opt_val;
			swk_trim_pkg::ADDR_CAL_HIGH: next_rdata = cal_high;
			swk_trim_pkg::ADDR_CAL_LOW: next_rdata = cal_low;
			swk_trim_pkg::ADDR_RECOVERY_ONE: next_rdata = one_val;
			swk_trim_pkg::ADDR_RECOVERY_TWO: next_rdata = two_val;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			rdata <= swk_trim_pkg::RST_RDATA;
		else
			rdata <= next_rdata;
	end

	// ------------------------------------------------------------
	// Trim and receiver select
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trim_low <= swk_trim_pkg::RST_TRIM_LOW;
			coarse <= swk_trim_pkg::RST_COARSE;
			rx_sel <= swk_trim_pkg::RST_RX_SEL;
		end else begin
			if (wr_trim && unlocked)
				trim_low <= req.wdata;
			if (wr_opt && unlocked) begin
				coarse <= req.wdata[swk_trim_pkg::COARSE_MSB:0];
				rx_sel <= req.wdata[swk_trim_pkg::RX_SEL_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Recovery controls
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			filt <= swk_trim_pkg::filt_sel_t'(swk_trim_pkg::RST_FILT);
			rec_en <= swk_trim_pkg::RST_ENABLE;
			clk_sel <= swk_trim_pkg::clk_sel_t'(swk_trim_pkg::RST_CLK_SEL);
		end else begin
			if (wr_one) begin
				filt <= swk_trim_pkg::filt_sel_t'(
					req.wdata[swk_trim_pkg::FILT_LSB +: 2]);
				rec_en <= req.wdata[swk_trim_pkg::ENABLE_BIT];
			end
			if (wr_two)
				clk_sel <= swk_trim_pkg::clk_sel_t'(req.wdata[1:0]);
		end
	end

	// ------------------------------------------------------------
	// Calibration status, no write path
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cal_high <= swk_trim_pkg::RST_CAL;
			cal_low <= swk_trim_pkg::RST_CAL;
		end else if (cal_valid) begin
			cal_high <= cal_value[15:8];
			cal_low <= cal_value[7:0];
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Fine steps in [4:0], temperature coefficient in [7:5]
	assign cfg.oscillator_trim = {coarse, trim_low};
	assign cfg.wake_receiver_select = rx_sel;
	assign cfg.filter_constant_select = filt;
	assign cfg.recovery_enable = rec_en;
	assign cfg.recovery_clock_select = clk_sel;

	function automatic logic [5:0] time_const(
		input swk_trim_pkg::filt_sel_t f, input logic [3:0] sp);
		case (f)
			swk_trim_pkg::FILT_8: time_const = swk_trim_pkg::TC_8;
			swk_trim_pkg::FILT_16: time_const = swk_trim_pkg::TC_16;
			swk_trim_pkg::FILT_32: time_const = swk_trim_pkg::TC_32;
			default: begin
				if (sp <= swk_trim_pkg::SPACE_SHORT_MAX)
					time_const = swk_trim_pkg::TC_32;
				else if (sp <= swk_trim_pkg::SPACE_MID_MAX)
					time_const = swk_trim_pkg::TC_16;
				else
					time_const = swk_trim_pkg::TC_8;
			end
		endcase
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n)
			filter_time_constant <= swk_trim_pkg::TC_16;
		else
			filter_time_constant <= time_const(filt, edge_spacing);
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_TRIM_LOCKED: assert property (@(posedge clk) disable iff (!rst_n)
		wr_trim && !unlocked |=> $stable(trim_low))
		else $error("Trim byte changed while locked");
	AST_TRIM_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		wr_trim && unlocked |=> trim_low == $past(req.wdata))
		else $error("Unlocked trim write not stored");
	AST_COARSE_LOCKED: assert property (@(posedge clk)
		disable iff (!rst_n)
		wr_opt && !unlocked |=> $stable(coarse) && $stable(rx_sel))
		else $error("Options changed while locked");
	AST_RX_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		wr_opt && unlocked |=> cfg.wake_receiver_select == $past(req.wdata[7]))
		else $error("Receiver select not taken");
	AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
		(req.addr == swk_trim_pkg::ADDR_RECOVERY_ONE
		|=> (rdata & ~swk_trim_pkg::MASK_RECOVERY_ONE) == 8'h00)
		and (req.addr == swk_trim_pkg::ADDR_WAKE_OPTIONS
		|=> (rdata & ~swk_trim_pkg::MASK_OPTIONS) == 8'h00))
		else $error("Reserved bits read nonzero");
	AST_CAL_RO: assert property (@(posedge clk) disable iff (!rst_n)
		!cal_valid |=> $stable(cal_high) && $stable(cal_low))
		else $error("Calibration changed without measurement");
	AST_FILT_FIXED: assert property (@(posedge clk) disable iff (!rst_n)
		filt == swk_trim_pkg::FILT_32 ##1 filt == swk_trim_pkg::FILT_32
		|-> filter_time_constant == swk_trim_pkg::TC_32)
		else $error("Fixed filter constant wrong");
	AST_FILT_ADAPT: assert property (@(posedge clk) disable iff (!rst_n)
		filt == swk_trim_pkg::FILT_ADAPT && edge_spacing >= 4'h9
		|=> filter_time_constant == swk_trim_pkg::TC_8)
		else $error("Adaptive constant wrong for wide spacing");
	AST_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
		wr_one |=> cfg.recovery_enable == $past(req.wdata[0]))
		else $error("Recovery enable not taken");
	AST_CLK_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		wr_two |=> cfg.recovery_clock_select == $past(req.wdata[1:0]))
		else $error("Recovery clock select not taken");
	AST_RESERVED_TWO: assert property (@(posedge clk)
		disable iff (!rst_n)
		req.addr == swk_trim_pkg::ADDR_RECOVERY_TWO
		|=> (rdata & ~swk_trim_pkg::MASK_RECOVERY_TWO) == 8'h00)
		else $error("Reserved control-two bits read nonzero");
	AST_FILT_EIGHT: assert property (@(posedge clk) disable iff (!rst_n)
		filt == swk_trim_pkg::FILT_8 ##1 filt == swk_trim_pkg::FILT_8
		|-> filter_time_constant == swk_trim_pkg::TC_8)
		else $error("Shortest filter constant wrong");
	AST_CAL_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
		cal_valid |=> {cal_high, cal_low} == $past(cal_value))
		else $error("Calibration bytes not loaded");

	COV_UNLOCK_WR: cover property (@(posedge clk) wr_trim && unlocked);
	COV_LOCK_WR: cover property (@(posedge clk) wr_opt && !unlocked);
	COV_ADAPT: cover property (@(posedge clk)
		filt == swk_trim_pkg::FILT_ADAPT);
	COV_CAL: cover property (@(posedge clk) cal_valid);
	COV_REC_EN: cover property (@(posedge clk) wr_one && req.wdata[0]);

endmodule

// >>> tb_top.sv
// Self-checking testbench for the trim and recovery register bank.
// Assumes swk_trim_pkg and swk_trim_regs are compiled before it.
`timescale 1ns/1ps

module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	swk_trim_pkg::reg_req_t req = '0;
	logic [1:0] trim_enable = 2'h0;
	logic cal_valid = 1'b0;
	logic [15:0] cal_value = 16'h0000;
	logic [3:0] edge_spacing = 4'h0;
	logic [7:0] rdata;
	swk_trim_pkg::cfg_t cfg;
	logic [5:0] filter_time_constant;
	int fail_count = 0;
	int tests_run = 0;
	logic [7:0] rst_val [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
	logic [7:0] rd_mask [6] = '{8'hff, 8'h9f, 8'h00, 8'h00, 8'h0d, 8'h03};
	logic [3:0] space [6] = '{4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'ha};
	logic [5:0] tc_exp [6] = '{6'h20, 6'h20, 6'h10, 6'h10, 6'h08, 6'h08};

	always #2 clk = ~clk;

	swk_trim_regs swk_trim_regs_i (
		.clk(clk),
		.rst_n(rst_n),
		.req(req),
		.trim_enable(trim_enable),
		.rdata(rdata),
		.cal_valid(cal_valid),
		.cal_value(cal_value),
		.edge_spacing(edge_spacing),
		.cfg(cfg),
		.filter_time_constant(filter_time_constant)
	);

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// Read data answers one cycle after the address is driven
	task automatic rd_check(input logic [6:0] a, input logic [7:0] exp);
		@(posedge clk);
		req.addr <= a;
		@(posedge clk);
		#1;
		check({8'h00, rdata}, {8'h00, exp});
	endtask

	task automatic print_verdict;
		if (fail_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd_check(7'h38 + 7'(i), rst_val[i]);
		end
		check(16'(filter_time_constant), 16'h0010);
		check(16'(cfg.recovery_enable), 16'h0000);
		rd_check(7'h40, 8'h00);
		// Locked trim and options refuse writes
		reg_write(7'h38, 8'hff);
		rd_check(7'h38, 8'h00);
		reg_write(7'h39, 8'hff);
		rd_check(7'h39, 8'h00);
		// Unlocked: writable bits stick, reserved read zero
		@(posedge clk);
		trim_enable <= 2'h3;
		for (int i = 0; i < 6; i++) begin
			reg_write(7'h38 + 7'(i), 8'hff);
			rd_check(7'h38 + 7'(i), rd_mask[i]);
		end
		check(16'(cfg.oscillator_trim), 16'h1fff);
		check(16'(cfg.wake_receiver_select), 16'h0001);
		check(16'(cfg.recovery_enable), 16'h0001);
		check(16'(cfg.recovery_clock_select), 16'h0003);
		// Adaptive filter follows falling-edge spacing
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			edge_spacing <= space[i];
			repeat (2) @(posedge clk);
			#1;
			check(16'(filter_time_constant), 16'(tc_exp[i]));
		end
		// Receiver change keeps coarse trim
		reg_write(7'h39, 8'h1f);
		reg_write(7'h38, 8'ha5);
		rd_check(7'h39, 8'h1f);
		check(16'(cfg.oscillator_trim), 16'h1fa5);
		check(16'(cfg.wake_receiver_select), 16'h0000);
		@(posedge clk);
		trim_enable <= 2'h2;
		reg_write(7'h39, 8'h80);
		rd_check(7'h39, 8'h1f);
		// Fixed filter codes with recovery disabled
		for (int c = 0; c < 3; c++) begin
			reg_write(7'h3c, {4'h0, 2'(c), 2'h0});
			rd_check(7'h3c, {4'h0, 2'(c), 2'h0});
			check(16'(filter_time_constant), 16'h0008 << c);
			check(16'(cfg.filter_constant_select), 16'(c));
			check(16'(cfg.recovery_enable), 16'h0000);
		end
		for (int c = 0; c < 4; c++) begin
			reg_write(7'h3d, 8'(c));
			rd_check(7'h3d, 8'(c));
			check(16'(cfg.recovery_clock_select), 16'(c));
		end
		// Calibration bytes load from measurement only
		@(posedge clk);
		cal_value <= 16'h5aa5;
		cal_valid <= 1'b1;
		@(posedge clk);
		cal_valid <= 1'b0;
		rd_check(7'h3a, 8'h5a);
		reg_write(7'h3b, 8'h00);
		rd_check(7'h3b, 8'ha5);
		// Mid-run reset restores calibration and recovery defaults
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rd_check(7'h3a, 8'h00);
		rd_check(7'h3c, 8'h04);
		check(16'(cfg.recovery_clock_select), 16'h0000);
		check(16'(filter_time_constant), 16'h0010);
		print_verdict();
	end
endmodule
